// File: bio_params.svh
`ifndef BIO_PARAMS_SVH
`define BIO_PARAMS_SVH
// ----------------------------------------
// Port addresses (data at even, direction at odd)
// ----------------------------------------
`define BIO_NUM_PORTS 5
`define BIO_ADDR_P0_DATA 8'h00
`define BIO_ADDR_P0_DIR 8'h01
`define BIO_ADDR_P1_DATA 8'h02
`define BIO_ADDR_P1_DIR 8'h03
`define BIO_ADDR_P2_DATA 8'h04
`define BIO_ADDR_P2_DIR 8'h05
`define BIO_ADDR_P3_DATA 8'h06
`define BIO_ADDR_P3_DIR 8'h07
`define BIO_ADDR_P4_DATA 8'h08
`define BIO_ADDR_P4_DIR 8'h09
`define BIO_ADDR_LAST 8'h09
// ----------------------------------------
// Reset values and field positions
// ----------------------------------------
`define BIO_RST_LATCH 8'h00
`define BIO_RST_DIR 8'h00
`define BIO_SHORT_MASK 8'h1F
`define BIO_BIT_RXD 0
`define BIO_BIT_TXD 1
`define BIO_BIT_SCK 2
`define BIO_BIT_RDY 3
`endif

// File: bio_pkg.sv
package bio_pkg;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
	} bio_req_s;
	// Alternate pin drive from the second serial unit, one per low pin of port 0
	typedef struct packed {
		logic [3:0] en;
		logic [3:0] oe_n;
		logic [3:0] dout;
	} bio_alt_s;
	typedef logic [7:0] bio_byte_t;
endpackage : bio_pkg

// File: bio_port.sv
`timescale 1ns/1ns
`include "bio_params.svh"
// Behaviour
// - Each pin has its own direction bit
// - Direction 0 input, 1 output driving latch
// - Output pins read back the latch
// - Input pins have driver disabled, floating
// - Writes to input pins update latch only
// - Ports 3 and 4 bits 5-7 undefined
// - Port 0 low pins shared with serial2
module bio_port (
	input wire logic clk_sys,
	input wire logic srst,
	input wire bio_pkg::bio_req_s cpu_req,
	output bio_pkg::bio_byte_t cpu_rdata,
	output logic cpu_addr_hit,
	input wire logic [39:0] pin_in,
	output logic [39:0] pin_out,
	output logic [39:0] pin_oe_n,
	input wire bio_pkg::bio_alt_s serial2_alt,
	output logic serial2_receive_in,
	output logic serial2_shift_clock_in,
	output logic serial2_ready_line_in
);
	import bio_pkg::*;
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [39:0] pin_meta_r;
	logic [39:0] pin_sync_r;
	always_ff @(posedge clk_sys) begin
		pin_meta_r <= pin_in;
		pin_sync_r <= pin_meta_r;
	end
	// ----------------------------------------
	// Per-port latch, direction and readback
	// ----------------------------------------
	logic [39:0] port_drive;
	logic [39:0] port_oe_n;
	logic [7:0] rd_data [0:4];
	logic [7:0] rd_dir [0:4];
	genvar gi;
	generate
		for (gi = 0; gi < `BIO_NUM_PORTS; gi = gi + 1) begin : g_port
			wire [7:0] a_data = 8'(2 * gi);
			wire [7:0] a_dir = 8'(2 * gi + 1);
			wire wr_data = cpu_req.wr && (cpu_req.addr == a_data);
			wire wr_dir = cpu_req.wr && (cpu_req.addr == a_dir);
			// Each port owns its registers so no vector has two process drivers
			logic [7:0] latch_r;
			logic [7:0] dir_r;
			wire [7:0] lat = latch_r;
			wire [7:0] dir = dir_r;
			wire [7:0] mix = (dir & lat) | (~dir & pin_sync_r[gi*8 +: 8]);
			// Unimplemented pins of short ports read as zero; software must ignore them
			wire [7:0] keep = (gi >= 3) ? `BIO_SHORT_MASK : 8'hFF;
			always_ff @(posedge clk_sys) begin
				if (srst) begin
					latch_r <= `BIO_RST_LATCH;
					dir_r <= `BIO_RST_DIR;
				end else begin
					if (wr_data) begin
						latch_r <= cpu_req.wdata;
					end
					if (wr_dir) begin
						dir_r <= cpu_req.wdata & keep;
					end
				end
			end
			assign rd_data[gi] = mix & keep;
			assign rd_dir[gi] = dir;
			assign port_drive[gi*8 +: 8] = lat & keep;
			assign port_oe_n[gi*8 +: 8] = ~(dir & keep);
		end
	endgenerate
	// ----------------------------------------
	// Alternate function muxing on port 0
	// ----------------------------------------
	logic [39:0] mux_out;
	logic [39:0] mux_oe_n;
	assign mux_out = {port_drive[39:4], (serial2_alt.en & serial2_alt.dout) |
		(~serial2_alt.en & port_drive[3:0])};
	assign mux_oe_n = {port_oe_n[39:4], (serial2_alt.en & serial2_alt.oe_n) |
		(~serial2_alt.en & port_oe_n[3:0])};
	assign serial2_receive_in = pin_sync_r[`BIO_BIT_RXD];
	assign serial2_shift_clock_in = pin_sync_r[`BIO_BIT_SCK];
	assign serial2_ready_line_in = pin_sync_r[`BIO_BIT_RDY];
	// ----------------------------------------
	// Registered pin and read-data outputs, combinational address hit
	// ----------------------------------------
	logic [7:0] rdata_nxt;
	logic hit_nxt;
	logic [39:0] out_r;
	logic [39:0] oe_n_r;
	logic [7:0] rdata_r;
	wire [3:0] sel = cpu_req.addr[4:1];
	assign hit_nxt = (cpu_req.addr <= `BIO_ADDR_LAST);
	assign rdata_nxt = !hit_nxt ? 8'h00 : (cpu_req.addr[0] ? rd_dir[sel[2:0]] : rd_data[sel[2:0]]);
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			out_r <= 40'h00_0000_0000;
			oe_n_r <= 40'hFF_FFFF_FFFF;
			rdata_r <= 8'h00;
		end else begin
			out_r <= mux_out;
			oe_n_r <= mux_oe_n;
			rdata_r <= rdata_nxt;
		end
	end
	assign pin_out = out_r;
	assign pin_oe_n = oe_n_r;
	assign cpu_rdata = rdata_r;
	assign cpu_addr_hit = hit_nxt;
endmodule : bio_port

// File: bio_asserts.sv
`timescale 1ns/1ns
module bio_asserts (
	input wire logic clk_sys,
	input wire logic srst,
	input wire bio_pkg::bio_req_s cpu_req,
	input wire bio_pkg::bio_byte_t cpu_rdata,
	input wire logic [39:0] pin_in,
	input wire logic [39:0] pin_out,
	input wire logic [39:0] pin_oe_n,
	input wire bio_pkg::bio_alt_s serial2_alt,
	input wire logic serial2_receive_in
);
	import bio_pkg::*;
	wire logic w = cpu_req.wr;
	wire logic [7:0] a = cpu_req.addr;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	sequence s_d; w && a == 8'h03; endsequence
	a_dir_drive: assert property (s_d |-> ##2 pin_oe_n[15:8] == ~$past(cpu_req.wdata, 2))
		else $error("dir");
	a_dir_alone: assert property (s_d ##0 !$past(w) |=> ##1 $stable(pin_oe_n[23:16]))
		else $error("alone");
	a_out_read: assert property (!w && !$past(w) && a == 8'h02 |=>
		((cpu_rdata ^ pin_out[15:8]) & ~pin_oe_n[15:8]) == 8'h00) else $error("read");
	a_reset_float: assert property ($fell(srst) |-> pin_oe_n == 40'hFFFFFFFFFF)
		else $error("float");
	a_latch_only: assert property (w && a == 8'h04 && !$past(w) && pin_oe_n[23:16] == 8'hFF
		|-> ##2 pin_oe_n[23:16] == 8'hFF) else $error("latch");
	a_short_hi: assert property (a == 8'h06 |=> cpu_rdata[7:5] == 3'h0) else $error("hi");
	a_rx_sync: assert property (!$past(srst, 2) |-> serial2_receive_in == $past(pin_in[0], 2))
		else $error("rx");
	a_alt_owns: assert property ($stable(serial2_alt) [*2] ##0 serial2_alt.en[1] |->
		pin_out[1] == serial2_alt.dout[1] && pin_oe_n[1] == serial2_alt.oe_n[1]) else $error("alt");
endmodule : bio_asserts
bind bio_port bio_asserts u_chk (.*);

// File: bio_pins.sv
`timescale 1ns/1ns
module bio_pins (
	input wire logic [39:0] pin_out,
	input wire logic [39:0] pin_oe_n,
	input wire logic [39:0] ext,
	output logic [39:0] pin_in
);
	// Outside circuit drives only floated pins, so no contention is modelled
	assign pin_in = (pin_oe_n & ext) | (~pin_oe_n & pin_out);
endmodule : bio_pins

// File: tb.sv
`timescale 1ns/1ns
`define CHK(n, e, v) begin compares++; if ((v) !== (e)) begin bad_count++; \
	$display("CHECK FAILED %s %h %h", n, e, v); end end
module tb;
	import bio_pkg::*;
	logic clk_sys = 1'h0, srst = 1'h1, cpu_addr_hit, serial2_receive_in, serial2_shift_clock_in;
	logic serial2_ready_line_in;
	logic [39:0] pin_in, pin_out, pin_oe_n, ext = 40'hC3C3C3C3C3;
	bio_req_s cpu_req = '0;
	bio_alt_s serial2_alt = '0;
	bio_byte_t cpu_rdata;
	int bad_count = 0, compares = 0;
	always #5 clk_sys = ~clk_sys;
	bio_port DUT (.*);
	bio_pins u_pins (.*);
	task automatic go(input logic [7:0] a, d, input logic w);
		@(negedge clk_sys) cpu_req = {a, d, w};
		@(negedge clk_sys) cpu_req.wr = 1'h0;
	endtask : go
	task automatic t_dir;
		go(8'h03, 8'h5A, 1'h1);
		go(8'h04, 8'hFF, 1'h1);
		go(8'h03, 8'h00, 1'h0);
		`CHK("p1 oe", 8'hA5, pin_oe_n[15:8])
		`CHK("p2 oe", 8'hFF, pin_oe_n[23:16])
		`CHK("p1 dir", 8'h5A, cpu_rdata)
		$display("t_dir end");
	endtask : t_dir
	task automatic t_read;
		go(8'h02, 8'h0F, 1'h1);
		go(8'h02, 8'h00, 1'h0);
		`CHK("p1 rd", 8'h8B, cpu_rdata)
		go(8'h04, 8'h00, 1'h0);
		`CHK("p2 rd", 8'hC3, cpu_rdata)
		go(8'h06, 8'h00, 1'h0);
		`CHK("p3 hi", 3'h0, cpu_rdata[7:5])
		$display("t_read end");
	endtask : t_read
	task automatic t_alt;
		serial2_alt = {4'hF, 4'h9, 4'h6};
		repeat (4) @(negedge clk_sys);
		`CHK("alt oe", 4'h9, pin_oe_n[3:0])
		`CHK("alt out", 2'h3, pin_out[2:1])
		`CHK("rx in", 1'h1, serial2_receive_in)
		`CHK("sck in", 1'h1, serial2_shift_clock_in)
		`CHK("rdy in", 1'h0, serial2_ready_line_in)
		$display("t_alt end");
	endtask : t_alt
	task automatic t_edge;
		go(8'h07, 8'hFF, 1'h1);
		go(8'h0A, 8'hFF, 1'h1);
		`CHK("hit off", 1'h0, cpu_addr_hit)
		`CHK("off rd", 8'h00, cpu_rdata)
		go(8'h07, 8'h00, 1'h0);
		`CHK("hit on", 1'h1, cpu_addr_hit)
		`CHK("p3 dir", 8'h1F, cpu_rdata)
		`CHK("p3 oe", 8'hE0, pin_oe_n[31:24])
		$display("t_edge end");
	endtask : t_edge
	task automatic end_of_test;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (12) @(negedge clk_sys);
		srst = 1'h0;
		t_dir;
		t_read;
		t_edge;
		t_alt;
		end_of_test;
	end
	// About five and a half times the expected run
	initial begin
		#2000;
		bad_count++;
		end_of_test;
	end
endmodule : tb
